// File: common/bcf_pkg.sv
/*
  Constants, types and register map for the breaker close and fault
  sequencer. Assumes a single 10 MHz system clock and an APB register bus.
*/
`default_nettype none

package bcf_pkg;

  // Clock rate and the one-second timebase derived from it
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SEC_TIME_S = 1;
  localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * SEC_TIME_S;

  // Close switch hold time before the warning starts
  localparam int unsigned HOLD_TIME_S = 2;

  // Close delay range and reset values of the protection timing
  localparam logic [2:0] CLOSE_DELAY_MAX = 3'h5;
  localparam logic [2:0] CLOSE_DELAY_RST = 3'h5;
  localparam logic [15:0] OVL_TIME_RST = 16'h021C;
  localparam logic [7:0] PCT_DELAY_RST = 8'h03;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_STATUS_OFS = 8'h0C;
  localparam logic [7:0] INT_MASK_OFS = 8'h10;

  // Field positions
  localparam int unsigned CTRL_DELAY_LSB = 0;
  localparam int unsigned CTRL_TYPE_LSB = 4;
  localparam int unsigned TIMING_OVL_LSB = 0;
  localparam int unsigned TIMING_PCT_LSB = 16;

  // Interrupt status and mask bits
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_CLOSED = 1;
  localparam int unsigned IRQ_ABANDON = 2;
  localparam int unsigned IRQ_REFUSED = 3;
  localparam int unsigned IRQ_W = 4;

  // Contactor ratings selectable by software
  typedef enum logic [1:0] {
    CONT_320A, CONT_450A, CONT_600A, CONT_800A
  } contactor_type_t;

  // Close sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_HOLD, SEQ_WARN_HELD, SEQ_PRECLOSE, SEQ_CLOSED
  } seq_state_t;

  // Four front panel keys
  typedef struct packed {
    logic select_key;
    logic return_key;
    logic [1:0] step_up_down_keys;
  } keypad_t;

  // Protection conditions from the measurement side
  typedef struct packed {
    logic inst_fault;
    logic overload;
    logic imbalance;
    logic undervolt;
  } prot_t;

  // Drives toward the contactor and the front panel
  typedef struct packed {
    logic contactor_close;
    logic fault_led;
    logic warn_led;
    logic alarm;
    logic fault_screen;
  } panel_t;

endpackage

`default_nettype wire

// File: hdl/breaker_close_fault_sequencer.sv
/*
  Breaker close and fault sequencer with APB register slave.
  Assumes all inputs synchronous to pclk and debounced elsewhere.
*/
// The implementer's own choices: the register offsets and the APB register port.
// Functional notes
// - Close delay is software settable from 0 to 5 seconds.
// - Close delay counts from close switch release, then contactor closes.
// - Any protection fault opens the contactor.
// - A fault shows the fault screen and lights the fault indicator at once.
// - Close requests are refused while a fault is latched.
// - Any of four keys clears the fault while the fault screen shows.
// - Without the fault screen shown, key presses do not clear the fault.
// - Holding close two seconds with no fault starts alarm and warn lamp.
// - Pre-close warning lasts the close delay, then the contactor closes.
// - Overload trips after the configured overload time, default 540 s.
// - One shared delay, default 3 s, for imbalance and undervoltage trips.
// - Contactor type offers four ratings: 320, 450, 600, 800 A.
// - Faults open the contactor on the next clock, ahead of any fuse.
`timescale 1ns/1ps
`default_nettype none

module breaker_close_fault_sequencer
  import bcf_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire keypad_t keys,
  input wire logic close_switch,
  input wire logic fault_menu_select,
  input wire logic menu_leave,
  input wire prot_t prot,
  output panel_t panel,
  output logic irq
);

  localparam logic [31:0] SEC_CYC = 32'(SEC_CYCLES);
  localparam logic [31:0] HOLD_CYC = 32'(HOLD_TIME_S * SEC_CYCLES);
  generate
    if (SEC_CYCLES < 1 || SEC_CYCLES > 32'h7FFFFFFF / HOLD_TIME_S) begin : g_bad
      $error("SEC_CYCLES out of range");
    end
  endgenerate
  // Register state
  logic [2:0] close_delay;
  contactor_type_t cont_type;
  logic [15:0] ovl_time;
  logic [7:0] pct_delay;
  logic [IRQ_W-1:0] int_status;
  logic [IRQ_W-1:0] int_mask;
  logic [2:0] next_close_delay;
  contactor_type_t next_cont_type;
  logic [15:0] next_ovl_time;
  logic [7:0] next_pct_delay;
  logic [IRQ_W-1:0] next_int_status;
  logic [IRQ_W-1:0] next_int_mask;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_irq;
  // Fault and timer state
  logic fault_latched;
  logic fault_screen;
  logic [31:0] tick_cnt;
  logic [15:0] ovl_secs;
  logic [7:0] pct_secs;
  logic [3:0] keys_prev;
  logic next_fault_latched;
  logic next_fault_screen;
  logic [31:0] next_tick_cnt;
  logic [15:0] next_ovl_secs;
  logic [7:0] next_pct_secs;
  // Sequencer state
  seq_state_t state;
  logic [31:0] seq_cnt;
  logic [2:0] seq_secs;
  logic close_prev;
  seq_state_t next_state;
  logic [31:0] next_seq_cnt;
  logic [2:0] next_seq_secs;
  panel_t next_panel;
  // Shared events
  logic sec_tick;
  logic ovl_trip;
  logic pct_trip;
  logic fault_detect;
  logic key_press;
  logic clear_ok;
  logic ev_closed;
  logic ev_abandon;
  logic ev_refused;
  logic wr_en;
  logic setup;
  // Clamp a requested delay into the selectable range
  function automatic logic [2:0] clamp_delay(input logic [2:0] d);
    return (d > CLOSE_DELAY_MAX) ? CLOSE_DELAY_MAX : d;
  endfunction
  // Zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & ~pslverr;
  // Register writes, read capture in setup and sticky interrupt bits
  always_comb begin
    next_close_delay = close_delay;
    next_cont_type = cont_type;
    next_ovl_time = ovl_time;
    next_pct_delay = pct_delay;
    next_int_mask = int_mask;
    next_int_status = int_status;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (wr_en) begin
      if (paddr == CTRL_OFS) begin
        next_close_delay = clamp_delay(pwdata[CTRL_DELAY_LSB +: 3]);
        next_cont_type = contactor_type_t'(pwdata[CTRL_TYPE_LSB +: 2]);
      end else if (paddr == TIMING_OFS) begin
        next_ovl_time = pwdata[TIMING_OVL_LSB +: 16];
        next_pct_delay = pwdata[TIMING_PCT_LSB +: 8];
      end else if (paddr == INT_STATUS_OFS) begin
        next_int_status = int_status & ~pwdata[IRQ_W-1:0];
      end else if (paddr == INT_MASK_OFS) begin
        next_int_mask = pwdata[IRQ_W-1:0];
      end
    end
    // Hardware set wins over a software clear in the same cycle
    next_int_status[IRQ_FAULT] |= fault_detect & ~fault_latched;
    next_int_status[IRQ_CLOSED] |= ev_closed;
    next_int_status[IRQ_ABANDON] |= ev_abandon;
    next_int_status[IRQ_REFUSED] |= ev_refused;
    // Read data is captured at setup so it is stable through access
    if (setup) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (paddr == CTRL_OFS) begin
        next_prdata[CTRL_DELAY_LSB +: 3] = close_delay;
        next_prdata[CTRL_TYPE_LSB +: 2] = cont_type;
      end else if (paddr == TIMING_OFS) begin
        next_prdata[TIMING_OVL_LSB +: 16] = ovl_time;
        next_prdata[TIMING_PCT_LSB +: 8] = pct_delay;
      end else if (paddr == STATUS_OFS) begin
        next_prdata[4:0] = panel;
        next_prdata[5] = fault_latched;
        next_prdata[10:8] = state;
      end else if (paddr == INT_STATUS_OFS) begin
        next_prdata[IRQ_W-1:0] = int_status;
      end else if (paddr == INT_MASK_OFS) begin
        next_prdata[IRQ_W-1:0] = int_mask;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    next_irq = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      close_delay <= CLOSE_DELAY_RST;
      cont_type <= CONT_320A;
      ovl_time <= OVL_TIME_RST;
      pct_delay <= PCT_DELAY_RST;
      int_status <= '0;
      int_mask <= '0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      close_delay <= next_close_delay;
      cont_type <= next_cont_type;
      ovl_time <= next_ovl_time;
      pct_delay <= next_pct_delay;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // Trip decisions; timers run on a free seconds tick, so up to 1 s late.
  // One tick past the setting is needed, so a trip never comes early.
  assign sec_tick = (tick_cnt == SEC_CYC - 32'h1);
  assign ovl_trip = prot.overload &&
                    (ovl_time == 16'h0000 || ovl_secs > ovl_time);
  assign pct_trip = (prot.imbalance || prot.undervolt) &&
                    (pct_delay == 8'h00 || pct_secs > pct_delay);
  assign fault_detect = prot.inst_fault | ovl_trip | pct_trip;
  assign key_press = |(keys & ~keys_prev);
  assign clear_ok = fault_latched && fault_screen && key_press;

  // Fault latch, fault screen and protection timers
  always_comb begin
    next_tick_cnt = sec_tick ? 32'h0 : tick_cnt + 32'h1;
    next_ovl_secs = ovl_secs;
    if (!prot.overload) begin
      next_ovl_secs = 16'h0000;
    end else if (sec_tick && ovl_secs != 16'hFFFF) begin
      next_ovl_secs = ovl_secs + 16'h0001;
    end
    next_pct_secs = pct_secs;
    if (!(prot.imbalance || prot.undervolt)) begin
      next_pct_secs = 8'h00;
    end else if (sec_tick && pct_secs != 8'hFF) begin
      next_pct_secs = pct_secs + 8'h01;
    end
    next_fault_screen = fault_screen;
    if (menu_leave) begin
      next_fault_screen = 1'b0;
    end
    if (fault_menu_select) begin
      next_fault_screen = 1'b1;
    end
    next_fault_latched = fault_latched;
    if (clear_ok) begin
      next_fault_latched = 1'b0;
    end
    // A fault in the clearing cycle still latches
    if (fault_detect) begin
      next_fault_latched = 1'b1;
      next_fault_screen = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_latched <= 1'b0;
      fault_screen <= 1'b0;
      tick_cnt <= 32'h0;
      ovl_secs <= 16'h0000;
      pct_secs <= 8'h00;
      keys_prev <= 4'h0;
    end else begin
      fault_latched <= next_fault_latched;
      fault_screen <= next_fault_screen;
      tick_cnt <= next_tick_cnt;
      ovl_secs <= next_ovl_secs;
      pct_secs <= next_pct_secs;
      keys_prev <= keys;
    end
  end

  // Close sequence: hold, warn while held, warn for the delay, close
  always_comb begin
    next_state = state;
    next_seq_cnt = seq_cnt + 32'h1;
    next_seq_secs = seq_secs;
    ev_closed = 1'b0;
    ev_abandon = 1'b0;
    ev_refused = 1'b0;
    case (state)
      SEQ_IDLE: begin
        next_seq_cnt = 32'h0;
        if (close_switch && !close_prev && fault_latched) begin
          ev_refused = 1'b1;
        end else if (close_switch && !fault_latched) begin
          next_state = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!close_switch) begin
          next_state = SEQ_IDLE;
          ev_abandon = 1'b1;
        end else if (seq_cnt == HOLD_CYC - 32'h1) begin
          next_state = SEQ_WARN_HELD;
        end
      end
      SEQ_WARN_HELD: begin
        next_seq_cnt = 32'h0;
        next_seq_secs = 3'h0;
        if (!close_switch) begin
          if (close_delay == 3'h0) begin
            next_state = SEQ_CLOSED;
            ev_closed = 1'b1;
          end else begin
            next_state = SEQ_PRECLOSE;
          end
        end
      end
      SEQ_PRECLOSE: begin
        if (seq_cnt == SEC_CYC - 32'h1) begin
          next_seq_cnt = 32'h0;
          next_seq_secs = seq_secs + 3'h1;
          if (seq_secs + 3'h1 >= close_delay) begin
            next_state = SEQ_CLOSED;
            ev_closed = 1'b1;
          end
        end
      end
      SEQ_CLOSED: begin
        next_seq_cnt = 32'h0;
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
    // A fault overrides every step and opens the contactor
    if (fault_detect) begin
      next_state = SEQ_IDLE;
      next_seq_cnt = 32'h0;
      ev_closed = 1'b0;
      ev_abandon = 1'b0;
    end
    next_panel.contactor_close = (next_state == SEQ_CLOSED);
    next_panel.warn_led = (next_state == SEQ_WARN_HELD) ||
                          (next_state == SEQ_PRECLOSE);
    next_panel.alarm = next_panel.warn_led;
    next_panel.fault_led = next_fault_latched;
    next_panel.fault_screen = next_fault_screen;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
      seq_cnt <= 32'h0;
      seq_secs <= 3'h0;
      close_prev <= 1'b0;
      panel <= '0;
    end else begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
      seq_secs <= next_seq_secs;
      close_prev <= close_switch;
      panel <= next_panel;
    end
  end

endmodule

`default_nettype wire

// File: dv/bcf_assertions.sv
/*
  Port checker for the breaker close and fault sequencer.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bcf_assertions
  import bcf_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire keypad_t keys,
  input wire logic close_switch,
  input wire prot_t prot,
  input wire panel_t panel
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int unsigned held;
  // Run length of the close switch, so the hold time is seen whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      held <= 0;
    else
      held <= close_switch ? held + 1 : 0;
  end
  property p_fault_open;
    prot.inst_fault |=> !panel.contactor_close;
  endproperty
  a_fault_open: assert property (p_fault_open)
    else $error("contactor not opened on fault");
  property p_fault_show;
    prot.inst_fault |=> panel.fault_led && panel.fault_screen;
  endproperty
  a_fault_show: assert property (p_fault_show)
    else $error("fault lamp or screen missing");
  property p_no_close;
    panel.fault_led |-> !panel.contactor_close && !panel.warn_led;
  endproperty
  a_no_close: assert property (p_no_close)
    else $error("close sequence while fault latched");
  property p_key_clear;
    panel.fault_led && panel.fault_screen && prot == 4'h0 &&
      (keys & ~$past(keys)) != 4'h0 |=> !panel.fault_led;
  endproperty
  a_key_clear: assert property (p_key_clear)
    else $error("key press did not clear fault");
  property p_key_keep;
    panel.fault_led && !panel.fault_screen |=> panel.fault_led;
  endproperty
  a_key_keep: assert property (p_key_keep)
    else $error("fault cleared without fault screen");
  property p_hold;
    $rose(panel.warn_led) |-> held >= 2 * SEC_CYCLES;
  endproperty
  a_hold: assert property (p_hold)
    else $error("warning before hold time");
  property p_warn_close;
    $rose(panel.contactor_close) |->
      $past(panel.warn_led) && !$past(close_switch);
  endproperty
  a_warn_close: assert property (p_warn_close)
    else $error("close without warning or release");
  property p_abandon;
    $fell(close_switch) && !panel.warn_led && !panel.contactor_close &&
      !panel.fault_led |=> !panel.warn_led [*4];
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("warning after early release");
  property p_slverr;
    psel && !penable && paddr > 8'h10 |=> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("no error on unmapped address");
endmodule
`default_nettype wire

// File: dv/bcf_operator_model.sv
/*
  Operator and plant model: keypad, close switch, menu and fault inputs.
  Assumes its tasks are called from the bench; drives after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module bcf_operator_model
  import bcf_pkg::*;
(
  input wire logic pclk,
  output var keypad_t keys,
  output logic close_switch,
  output logic fault_menu_select,
  output logic menu_leave,
  output var prot_t prot
);
  // Everything idle from time zero
  initial begin
    keys = 4'h0;
    close_switch = 1'b0;
    fault_menu_select = 1'b0;
    menu_leave = 1'b0;
    prot = 4'h0;
  end
  // Hold the close switch for n cycles, only then let go
  task automatic push_close(input int n);
    @(posedge pclk);
    close_switch <= 1'b1;
    repeat (n) @(posedge pclk);
    close_switch <= 1'b0;
  endtask
  // Two cycle press so a slow sampler still sees it
  task automatic press(input int k);
    @(posedge pclk);
    keys <= 4'h1 << k;
    repeat (2) @(posedge pclk);
    keys <= 4'h0;
  endtask
  // Fault source f present for n cycles
  task automatic trip(input int f, input int n);
    @(posedge pclk);
    prot <= 4'h1 << f;
    repeat (n) @(posedge pclk);
    prot <= 4'h0;
  endtask
  // Operator shows or leaves the fault screen
  task automatic screen(input logic on);
    @(posedge pclk);
    fault_menu_select <= on;
    menu_leave <= !on;
    @(posedge pclk);
    fault_menu_select <= 1'b0;
    menu_leave <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
/*
  Testbench: APB register checks, fault latch and clear, close sequences.
  Assumes the short timebase of ten cycles a second.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcf_pkg::*;
  localparam int unsigned S = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  keypad_t keys;
  logic close_switch;
  logic fault_menu_select;
  logic menu_leave;
  prot_t prot;
  panel_t panel;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int check_count = 0;
  int n;
  int dl[3] = '{0, 2, 5};
  int src[3] = '{2, 1, 0};
  breaker_close_fault_sequencer #(.SEC_CYCLES(S)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keys(keys),
    .close_switch(close_switch), .fault_menu_select(fault_menu_select),
    .menu_leave(menu_leave), .prot(prot), .panel(panel), .irq(irq));
  bcf_operator_model op (
    .pclk(pclk), .keys(keys), .close_switch(close_switch),
    .fault_menu_select(fault_menu_select), .menu_leave(menu_leave),
    .prot(prot));
  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; result lands in rd and er
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for a panel bit to go high
  task automatic wait_bit(input int b, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge pclk);
      if (panel[b] === 1'b1) break;
    end
    if (n == lim) begin
      err_count++;
      print_verdict();
    end
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, TIMING_OFS, 32'h0);
    chk(rd, 32'h3021C);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, CTRL_OFS, (t << 4) | 2);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, (t << 4) | 2);
    end
    apb(1'b1, CTRL_OFS, 32'h7);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd[2:0], 3'h5);
    apb(1'b1, TIMING_OFS, 32'h10002);
    apb(1'b1, INT_MASK_OFS, 32'h1 << IRQ_FAULT);
    apb(1'b0, INT_MASK_OFS, 32'h0);
    chk(rd, 32'h1);
    // Latch, refuse, then clear with each key in turn
    for (int k = 0; k < 4; k++) begin
      op.trip(3, 1);
      repeat (2) @(negedge pclk);
      chk(panel, 5'h09);
      chk(irq, 1'b1);
      op.screen(1'b0);
      op.press(k);
      @(negedge pclk);
      chk(panel.fault_led, 1'b1);
      op.push_close(2 * S + 5);
      @(negedge pclk);
      chk(panel.warn_led, 1'b0);
      op.screen(1'b1);
      op.press(k);
      @(negedge pclk);
      chk(panel.fault_led, 1'b0);
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      chk(rd[3:0], 4'h9);
      apb(1'b1, INT_STATUS_OFS, 32'hF);
      repeat (2) @(negedge pclk);
      chk(irq, 1'b0);
    end
    // Close with delays 0, 2 and 5, then trip on a timed fault
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, CTRL_OFS, dl[j]);
      fork
        op.push_close(2 * S + 4);
        begin
          // Last low point: one edge before the hold time is complete
          repeat (2 * S + 2) @(negedge pclk);
          chk(panel.warn_led, 1'b0);
        end
      join
      @(negedge pclk);
      chk({panel.warn_led, panel.alarm}, 2'h3);
      wait_bit(4, 6 * S);
      chk(n >= dl[j] * S && n <= dl[j] * S + 3, 1'b1);
      @(negedge pclk);
      chk(panel.warn_led, 1'b0);
      apb(1'b0, INT_STATUS_OFS, 32'h0);
      chk(rd[3:0], 4'h2);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd, 32'h411);
      // A trip of N seconds must land between N and N+1 seconds
      fork
        op.trip(src[j], 4 * S);
        begin
          repeat ((src[j] == 2 ? 2 : 1) * S + 3) @(negedge pclk);
          chk(panel.fault_led, 1'b0);
          wait_bit(3, S);
          chk(panel.contactor_close, 1'b0);
        end
      join
      op.press(j);
      apb(1'b1, INT_STATUS_OFS, 32'hF);
    end
    // Early release gives up without warning; event stays masked
    op.push_close(S);
    repeat (30) @(negedge pclk);
    chk(panel, 5'h01);
    chk(irq, 1'b0);
    apb(1'b0, INT_STATUS_OFS, 32'h0);
    chk(rd[3:0], 4'h4);
    print_verdict();
  end
endmodule
bind breaker_close_fault_sequencer bcf_assertions #(
  .SEC_CYCLES(SEC_CYCLES)
) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .keys(keys),
  .close_switch(close_switch), .prot(prot), .panel(panel));
`default_nettype wire
